// File: core/csc_pkg.sv
// shared constants and types of the clock supervisor counter
package csc_pkg;
    localparam int unsigned CSC_CLK_HZ = 20_000_000;
    localparam int unsigned CSC_ADR_W = 16;
    localparam int unsigned CSC_IDX_W = 14;
    // register indices; byte address is four times the index
    localparam logic [13:0] CSC_CTRL_IDX = 14'h0FE9;
    localparam logic [13:0] CSC_RESULT_IDX = 14'h0FEA;
    localparam logic [7:0] CSC_CTRL_RST = 8'h00;
    localparam logic [7:0] CSC_RESULT_RST = 8'h00;
    // control field positions
    localparam int unsigned CSC_EN_BIT = 0;
    localparam int unsigned CSC_WIN_LSB = 1;
    localparam int unsigned CSC_WIN_W = 3;
    localparam int unsigned CSC_SRC_BIT = 4;
    localparam int unsigned CSC_RSV_BIT = 5;
    localparam logic [2:0] CSC_WIN_RST = 3'h0;
    // counter limits
    localparam logic [7:0] CSC_CNT_MAX = 8'hFF;
    localparam logic [7:0] CSC_CNT_RST = 8'h00;
    localparam int unsigned CSC_TB_W = 17;
    localparam logic [16:0] CSC_TB_RST = 17'h00000;
    localparam logic [4:0] CSC_TAP_BASE = 5'h02;
    localparam logic [1:0] CSC_STALL_LIMIT = 2'h2;
    localparam logic [1:0] CSC_STALL_RST = 2'h0;

    typedef enum logic [2:0] {
        CSC_IDLE = 3'b001,
        CSC_PEND = 3'b010,
        CSC_RUN = 3'b100
    } csc_state_t;
endpackage : csc_pkg

// File: core/csc_reg_if.sv
// register access signals between the bus slave and the counter core
`timescale 1ns/1ps
interface csc_reg_if;
    logic wr_ctrl;
    logic wr_result;
    logic [7:0] wdata;
    logic [7:0] rd_ctrl;
    logic [7:0] rd_result;
    modport slave (output wr_ctrl, output wr_result, output wdata, input rd_ctrl, input rd_result);
    modport core (input wr_ctrl, input wr_result, input wdata, output rd_ctrl, output rd_result);
endinterface : csc_reg_if

// File: core/csc_edge_sync.sv
// two-flop synchroniser with rising edge pulse
`timescale 1ns/1ps
module csc_edge_sync (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic async_i,
    output logic rise_o
);
    logic meta_q;
    logic sync_q;
    logic last_q;

    // meta_q feeds only sync_q
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    assign rise_o = sync_q & ~last_q;
endmodule : csc_edge_sync

// File: core/csc_wb_slave.sv
// classic wishbone slave for the two byte-wide registers
`timescale 1ns/1ps
module csc_wb_slave
    import csc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [15:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [3:0] sel_i,
    input wire logic we_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    csc_reg_if.slave regs
);
    logic ack_q;
    logic [31:0] dat_q;
    logic req;
    logic take;
    logic hit_ctrl;
    logic hit_result;

    assign hit_ctrl = (adr_i[15:2] == CSC_CTRL_IDX);
    assign hit_result = (adr_i[15:2] == CSC_RESULT_IDX);
    assign req = cyc_i & stb_i & ~ack_q;
    // write lands on the edge where the master sees ack
    assign take = cyc_i & stb_i & ack_q & we_i & sel_i[0];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req;
        end
    end

    // unmapped addresses still ack, reading zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_q <= 32'h00000000;
        end else if (req & ~we_i) begin
            if (hit_ctrl) begin
                dat_q <= {24'h000000, regs.rd_ctrl};
            end else if (hit_result) begin
                dat_q <= {24'h000000, regs.rd_result};
            end else begin
                dat_q <= 32'h00000000;
            end
        end
    end

    assign regs.wr_ctrl = take & hit_ctrl;
    assign regs.wr_result = take & hit_result;
    assign regs.wdata = dat_i[7:0];
    assign ack_o = ack_q;
    assign dat_o = dat_q;
endmodule : csc_wb_slave

// File: core/csc_top.sv
// clock supervisor counter: measures an external clock against a time-base window
//
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/1ps
module csc_top
    import csc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [15:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic main_osc_clk_i,
    input wire logic main_pll_clk_i,
    input wire logic sub_osc_clk_i,
    input wire logic pll_select_i
);
    csc_reg_if regs ();

    csc_state_t state_q;
    logic [2:0] win_q;
    logic src_q;
    logic rsv_q;
    logic [7:0] cnt_q;
    logic [7:0] result_q;
    logic [1:0] stall_q;
    logic [16:0] tb_q;
    logic tbt_q;
    logic tbt_d1_q;
    logic retap_q;
    logic [4:0] tap_idx;
    logic tbt_rise;
    logic tbt_fall;
    logic osc_rise;
    logic pll_rise;
    logic sub_rise;
    logic src_rise;
    logic busy;
    logic start;
    logic abort;
    logic finish;
    logic stall_hit;

    csc_wb_slave u_slave (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .adr_i(wb_adr_i),
        .dat_i(wb_dat_i),
        .sel_i(wb_sel_i),
        .we_i(wb_we_i),
        .cyc_i(wb_cyc_i),
        .stb_i(wb_stb_i),
        .dat_o(wb_dat_o),
        .ack_o(wb_ack_o),
        .regs(regs.slave)
    );

    // sources must stay below half of clk_i to be seen
    csc_edge_sync u_osc (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(main_osc_clk_i),
        .rise_o(osc_rise)
    );

    csc_edge_sync u_pll (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(main_pll_clk_i),
        .rise_o(pll_rise)
    );

    csc_edge_sync u_sub (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(sub_osc_clk_i),
        .rise_o(sub_rise)
    );

    // select after synchronising, so a switch cannot tear a flop
    assign src_rise = src_q ? sub_rise : (pll_select_i ? pll_rise : osc_rise);

    // free-running time base; clk_i stands in for the main cr clock
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tb_q <= CSC_TB_RST;
        end else begin
            tb_q <= tb_q + 17'h00001;
        end
    end

    // tap 2w+2 toggles with a period of 2^(2w+3) cycles
    assign tap_idx = {1'b0, win_q, 1'b0} + CSC_TAP_BASE;

    // a tap switch must not pass for an interval edge, or the window opens early
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tbt_q <= 1'b0;
            tbt_d1_q <= 1'b0;
            retap_q <= 1'b0;
        end else begin
            retap_q <= regs.wr_ctrl & (regs.wdata[CSC_WIN_LSB +: CSC_WIN_W] != win_q);
            tbt_q <= tb_q[tap_idx];
            tbt_d1_q <= retap_q ? tb_q[tap_idx] : tbt_q;
        end
    end

    assign tbt_rise = tbt_q & ~tbt_d1_q & ~retap_q;
    assign tbt_fall = ~tbt_q & tbt_d1_q & ~retap_q;

    assign busy = (state_q != CSC_IDLE);
    assign start = regs.wr_ctrl & regs.wdata[CSC_EN_BIT] & ~busy;
    assign abort = regs.wr_ctrl & ~regs.wdata[CSC_EN_BIT] & busy;
    assign finish = (state_q == CSC_RUN) & tbt_rise;
    assign stall_hit = busy & tbt_fall & ~src_rise & (stall_q == CSC_STALL_LIMIT - 2'h1);

    // configuration fields; bits 7:6 are not stored
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            win_q <= CSC_WIN_RST;
            src_q <= 1'b0;
            rsv_q <= 1'b0;
        end else if (regs.wr_ctrl) begin
            win_q <= regs.wdata[CSC_WIN_LSB +: CSC_WIN_W];
            src_q <= regs.wdata[CSC_SRC_BIT];
            rsv_q <= regs.wdata[CSC_RSV_BIT];
        end
    end

    // measurement sequencer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= CSC_IDLE;
        end else if (start) begin
            state_q <= CSC_PEND;
        end else if (abort | stall_hit) begin
            state_q <= CSC_IDLE;
        end else begin
            case (state_q)
                CSC_IDLE: begin
                    state_q <= CSC_IDLE;
                end
                CSC_PEND: begin
                    if (tbt_rise) begin
                        state_q <= CSC_RUN;
                    end
                end
                CSC_RUN: begin
                    if (tbt_rise) begin
                        state_q <= CSC_IDLE;
                    end
                end
                default: begin
                    state_q <= CSC_IDLE;
                end
            endcase
        end
    end

    // internal counter, saturating
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= CSC_CNT_RST;
        end else if (start) begin
            cnt_q <= CSC_CNT_RST;
        end else if ((state_q == CSC_RUN) & src_rise & ~tbt_rise & (cnt_q != CSC_CNT_MAX)) begin
            cnt_q <= cnt_q + 8'h01;
        end
    end

    // interval falls since the last source edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stall_q <= CSC_STALL_RST;
        end else if (start | src_rise) begin
            stall_q <= CSC_STALL_RST;
        end else if (busy & tbt_fall & (stall_q != CSC_STALL_LIMIT)) begin
            stall_q <= stall_q + 2'h1;
        end
    end

    // result: zero while busy, so a read never shows a running count
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            result_q <= CSC_RESULT_RST;
        end else if (start) begin
            result_q <= CSC_RESULT_RST;
        end else if (abort | stall_hit) begin
            result_q <= CSC_RESULT_RST;
        end else if (finish) begin
            result_q <= cnt_q;
        end
    end

    // wr_result is decoded but deliberately has no effect
    assign regs.rd_result = result_q;
    assign regs.rd_ctrl = {2'b00, rsv_q, src_q, win_q, busy};

    property p_start_clears;
        @(posedge clk_i) disable iff (rst_i)
        start |=> (result_q == CSC_RESULT_RST) && (state_q == CSC_PEND) && (cnt_q == CSC_CNT_RST);
    endproperty
    a_start_clears: assert property (p_start_clears) else $error("start did not clear result");

    property p_abort;
        @(posedge clk_i) disable iff (rst_i)
        abort |=> (result_q == CSC_RESULT_RST) && (state_q == CSC_IDLE);
    endproperty
    a_abort: assert property (p_abort) else $error("abort did not stop and clear");

    property p_busy_zero;
        @(posedge clk_i) disable iff (rst_i)
        busy |-> (regs.rd_result == 8'h00);
    endproperty
    a_busy_zero: assert property (p_busy_zero) else $error("result nonzero while busy");

    property p_finish_load;
        @(posedge clk_i) disable iff (rst_i)
        (finish && !regs.wr_ctrl) |=> (state_q == CSC_IDLE) && (result_q == $past(cnt_q));
    endproperty
    a_finish_load: assert property (p_finish_load) else $error("final count not captured");

    property p_pend_run;
        @(posedge clk_i) disable iff (rst_i)
        ((state_q == CSC_PEND) && tbt_rise && !regs.wr_ctrl && !stall_hit) |=> (state_q == CSC_RUN);
    endproperty
    a_pend_run: assert property (p_pend_run) else $error("window did not open on rise");

    property p_saturate;
        @(posedge clk_i) disable iff (rst_i)
        ((state_q == CSC_RUN) && (cnt_q == CSC_CNT_MAX) && !start) |=> (cnt_q == CSC_CNT_MAX);
    endproperty
    a_saturate: assert property (p_saturate) else $error("counter wrapped past 255");

    property p_count_step;
        @(posedge clk_i) disable iff (rst_i)
        ((state_q == CSC_RUN) && src_rise && !tbt_rise && (cnt_q < CSC_CNT_MAX)) |=> (cnt_q == $past(cnt_q) + 8'h01);
    endproperty
    a_count_step: assert property (p_count_step) else $error("source edge not counted");

    property p_stall;
        @(posedge clk_i) disable iff (rst_i)
        (busy && tbt_fall && !src_rise && (stall_q == 2'h1) && !regs.wr_ctrl) |=> !busy && (result_q == 8'h00);
    endproperty
    a_stall: assert property (p_stall) else $error("stopped clock not detected");

    property p_result_ro;
        @(posedge clk_i) disable iff (rst_i)
        (regs.wr_result && !busy && !regs.wr_ctrl) |=> $stable(result_q);
    endproperty
    a_result_ro: assert property (p_result_ro) else $error("result changed by a write");

    property p_reset_vals;
        @(posedge clk_i)
        rst_i |=> (result_q == 8'h00) && (regs.rd_ctrl == 8'h00);
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("registers not zero after reset");

    property p_ctrl_top;
        @(posedge clk_i) disable iff (rst_i)
        regs.wr_ctrl |=> (regs.rd_ctrl[7:6] == 2'b00) && (regs.rd_ctrl[5:1] == $past(regs.wdata[5:1]));
    endproperty
    a_ctrl_top: assert property (p_ctrl_top) else $error("control readback wrong");

    property p_busy_flag;
        @(posedge clk_i) disable iff (rst_i)
        start |=> regs.rd_ctrl[CSC_EN_BIT] ##1 regs.rd_ctrl[CSC_EN_BIT];
    endproperty
    a_busy_flag: assert property (p_busy_flag) else $error("enable not shown while busy");

    property p_sel_src;
        @(posedge clk_i) disable iff (rst_i)
        src_q |-> (src_rise == sub_rise);
    endproperty
    a_sel_src: assert property (p_sel_src) else $error("sub oscillator not selected");

    property p_window;
        @(posedge clk_i) disable iff (rst_i)
        (finish && (win_q == 3'h0) && !regs.wr_ctrl) |-> $past(tbt_rise, 8);
    endproperty
    a_window: assert property (p_window) else $error("shortest window not 8 cycles");
endmodule : csc_top

// File: tb/csc_testbench.sv
// self-checking testbench of the clock supervisor counter
`timescale 1ns/1ps
module testbench
    import csc_pkg::*;
;
    localparam logic [15:0] ADR_CTRL = {CSC_CTRL_IDX, 2'b00};
    localparam logic [15:0] ADR_RES = {CSC_RESULT_IDX, 2'b00};
    logic clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, main_run;
    logic [15:0] wb_adr_i;
    logic [31:0] wb_dat_i, wb_dat_o, rdat;
    logic [3:0] wb_sel_i;
    logic main_osc_clk_i, main_pll_clk_i, sub_osc_clk_i, pll_select_i;
    logic [7:0] div_q;
    int n_mismatch, n_compared, cycles;

    csc_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
        .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .main_osc_clk_i(main_osc_clk_i),
        .main_pll_clk_i(main_pll_clk_i), .sub_osc_clk_i(sub_osc_clk_i), .pll_select_i(pll_select_i));

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    // sources derived from clk: main 8, pll 16, sub 32 cycles per period
    always @(posedge clk_i) begin
        div_q <= div_q + 8'h01;
        main_osc_clk_i <= main_run & div_q[2];
        main_pll_clk_i <= div_q[3];
        sub_osc_clk_i <= div_q[4];
    end

    // hang guard, worst case is a long saturation window
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            n_mismatch++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test

    task automatic fail(input string msg);
        n_mismatch++;
        $display("ERROR t=%0t %s", $time, msg);
    endtask : fail

    // classic single cycle; holds everything until ack is sampled
    task automatic wb_xfer(input logic we, input logic [15:0] adr, input logic [7:0] d, output logic [31:0] q);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= {24'h000000, d};
        wb_sel_i <= 4'h1;
        // only the bench timeout ends a wait for ack
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask : wb_xfer

    task automatic wr(input logic [15:0] adr, input logic [7:0] d);
        logic [31:0] q;
        wb_xfer(1'b1, adr, d, q);
    endtask : wr

    task automatic chk(input logic [15:0] adr, input logic [7:0] exp);
        wb_xfer(1'b0, adr, 8'h00, rdat);
        n_compared++;
        if (rdat !== {24'h000000, exp}) fail($sformatf("read %h at %h expected %h", rdat, adr, exp));
    endtask : chk

    task automatic chk_rng(input logic [7:0] lo, input logic [7:0] hi);
        wb_xfer(1'b0, ADR_RES, 8'h00, rdat);
        n_compared++;
        if (rdat[31:8] !== 24'h000000 || !(rdat[7:0] >= lo && rdat[7:0] <= hi))
            fail($sformatf("count %h outside %h to %h", rdat, lo, hi));
    endtask : chk_rng

    // polling is the only completion signal software has
    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            wb_xfer(1'b0, ADR_CTRL, 8'h00, rdat);
            n++;
        end while (rdat[0] !== 1'b0 && n < 8000);
        if (rdat[0] !== 1'b0) fail("measurement never ended");
    endtask : wait_idle

    task automatic t_reset_values();
        chk(ADR_CTRL, CSC_CTRL_RST);
        chk(ADR_RES, CSC_RESULT_RST);
    endtask : t_reset_values

    task automatic t_fields();
        logic [2:0] w;
        for (int i = 0; i < 8; i++) begin
            w = 3'(i);
            wr(ADR_CTRL, {2'b11, 1'b0, w[0], w, 1'b0});
            chk(ADR_CTRL, {2'b00, 1'b0, w[0], w, 1'b0});
        end
        wr(ADR_CTRL, 8'hC0);
        chk(ADR_CTRL, 8'h00);
        wr(ADR_RES, 8'hA5);
        chk(ADR_RES, 8'h00);
        chk(16'h0000, 8'h00);
        wr(ADR_CTRL, 8'h00);
    endtask : t_fields

    task automatic t_measure(input logic [2:0] win, input logic src, input logic pll, input logic [7:0] exp);
        pll_select_i <= pll;
        wr(ADR_CTRL, {3'b000, src, win, 1'b1});
        chk(ADR_CTRL, {3'b000, src, win, 1'b1});
        chk(ADR_RES, 8'h00);
        wait_idle();
        chk(ADR_CTRL, {3'b000, src, win, 1'b0});
        if (exp == 8'hFF) begin
            chk(ADR_RES, 8'hFF);
            wr(ADR_RES, 8'h00);
            chk(ADR_RES, 8'hFF);
        end else begin
            chk_rng(exp - 8'h01, exp + 8'h01);
        end
    endtask : t_measure

    task automatic t_restart_abort();
        wr(ADR_CTRL, 8'h05);
        chk(ADR_RES, 8'h00);
        wr(ADR_CTRL, 8'h04);
        chk(ADR_CTRL, 8'h04);
        repeat (300) @(posedge clk_i);
        chk(ADR_CTRL, 8'h04);
        chk(ADR_RES, 8'h00);
    endtask : t_restart_abort

    // stopped source, started just after a window rise: the stall ends it ~64 cycles before the window would
    task automatic t_stall();
        main_run <= 1'b0;
        while ((cycles % 128) != 72) begin
            @(posedge clk_i);
        end
        wr(ADR_CTRL, 8'h05);
        repeat (215) @(posedge clk_i);
        chk(ADR_CTRL, 8'h04);
        chk(ADR_RES, 8'h00);
        wait_idle();
        main_run <= 1'b1;
    endtask : t_stall

    initial begin
        rst_i = 1'b1;
        wb_adr_i = '0;
        wb_dat_i = '0;
        wb_sel_i = 4'h1;
        wb_we_i = 1'b0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        pll_select_i = 1'b0;
        main_run = 1'b1;
        div_q = 8'h00;
        main_osc_clk_i = 1'b0;
        main_pll_clk_i = 1'b0;
        sub_osc_clk_i = 1'b0;
        cycles = 0;
        n_mismatch = 0;
        n_compared = 0;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset_values();
        t_fields();
        t_measure(3'h2, 1'b0, 1'b0, 8'd16);
        t_measure(3'h2, 1'b0, 1'b1, 8'd8);
        t_measure(3'h2, 1'b1, 1'b0, 8'd4);
        t_measure(3'h1, 1'b0, 1'b0, 8'd4);
        t_measure(3'h0, 1'b0, 1'b0, 8'd1);
        t_measure(3'h5, 1'b0, 1'b0, 8'hFF);
        t_restart_abort();
        t_stall();
        end_of_test();
    end
endmodule : testbench
